// ===== rtl/tpc_pkg.sv
// Constants, register map and encodings for the timer control block.
// Assumes a single 250 MHz clock and a plain strobe register port.
//
// Summary of operation
// - Prescale codes 0-7 divide clock 1..1024
// - Counter and waveforms run only when enabled
// - Output enable routes waveform onto pin
// - Auto-lock holds lock until enabled compare buffers valid
// - Lock clears, sets again at update
// - Without auto-lock, hardware never touches lock
// - Mode sets top, update, overflow points
// - Normal mode drives no waveform
// - Disabled: output value bits drive waveform
// - Split select only drives split_mode_select_out; counter stays 16-bit
// - Clear register: ones clear control bits
// - Set register: ones set control bits
// - Command field: none, update, restart, reset
// - Hard reset ignored while enabled
// - Command field always reads zero
// - Lock set blocks buffer transfer
// - Lock clear transfers at update
// - Direction zero counts up, one down
// - Hardware or software may change direction
// - Buffer valid sets on write, clears at update
package tpc_pkg;
   localparam logic [7:0] TPC_OFS_CTRL_A    = 8'h00;
   localparam logic [7:0] TPC_OFS_MODE      = 8'h01;
   localparam logic [7:0] TPC_OFS_LEVEL     = 8'h02;
   localparam logic [7:0] TPC_OFS_SPLIT     = 8'h03;
   localparam logic [7:0] TPC_OFS_CMD_CLR   = 8'h04;
   localparam logic [7:0] TPC_OFS_CMD_SET   = 8'h05;
   localparam logic [7:0] TPC_OFS_BV_CLR    = 8'h06;
   localparam logic [7:0] TPC_OFS_BV_SET    = 8'h07;
   localparam logic [7:0] TPC_OFS_COUNT     = 8'h20;
   localparam logic [7:0] TPC_OFS_TOP       = 8'h26;
   localparam logic [7:0] TPC_OFS_CMP0      = 8'h28;
   localparam logic [7:0] TPC_OFS_TOP_BUF   = 8'h36;
   localparam logic [7:0] TPC_OFS_CMP0_BUF  = 8'h38;
   localparam logic [7:0] TPC_RST_BYTE      = 8'h00;
   localparam logic [15:0] TPC_RST_TOP      = 16'hffff;
   localparam logic [15:0] TPC_RST_WORD     = 16'h0000;
   localparam int TPC_CH                    = 3;
   localparam int TPC_BIT_AUTO_LOCK_UPDATE             = 3;
   localparam int TPC_BIT_CMPEN             = 4;
   localparam logic [2:0] TPC_WG_NORMAL     = 3'h0;
   localparam logic [2:0] TPC_WG_FREQ       = 3'h1;
   localparam logic [2:0] TPC_WG_ONE_RAMP   = 3'h3;
   localparam logic [2:0] TPC_WG_DS_TOP     = 3'h5;
   localparam logic [2:0] TPC_WG_DS_BOTH    = 3'h6;
   localparam logic [2:0] TPC_WG_DS_BOTTOM  = 3'h7;
   localparam logic [1:0] TPC_CMD_NONE      = 2'h0;
   localparam logic [1:0] TPC_CMD_UPDATE    = 2'h1;
   localparam logic [1:0] TPC_CMD_RESTART   = 2'h2;
   localparam logic [1:0] TPC_CMD_RESET     = 2'h3;
endpackage : tpc_pkg

// ===== rtl/tpc_timer.sv
// Timer control block: 16-bit counter, three compare channels, control regs.
// Registers over address/strobe port; read data valid one cycle after strobe.
`timescale 1ns/1ns
`default_nettype none
module tpc_timer
   import tpc_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                reset_n_in,
   input  wire logic                clk_en_in,
   input  wire logic [7:0]          addr_in,
   input  wire logic [7:0]          wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output logic      [7:0]          rdata_out,
   output logic      [TPC_CH-1:0]   waveform_output_n_out,
   output logic      [TPC_CH-1:0]   pin_override_out,
   output logic                     overflow_out,
   output logic                     split_mode_select_out
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  ctrl_a_reg;
   logic [7:0]  mode_reg;
   logic [2:0]  level_reg;
   logic        split_reg;
   logic        lock_update_reg;
   logic        dir_reg;
   logic [3:0]  bv_reg;
   logic [15:0] count_reg;
   logic [15:0] top_reg;
   logic [15:0] top_buf_reg;
   logic [15:0] cmp_reg [TPC_CH];
   logic [15:0] cbuf_reg [TPC_CH];
   logic [9:0]  pre_reg;
   logic [7:0]  temp_reg;
   logic [7:0]  rdata_reg;
   logic [TPC_CH-1:0] wave_reg;
   logic [TPC_CH-1:0] ovr_reg;
   logic        ovf_reg;

   wire         enable      = ctrl_a_reg[0];
   wire [2:0]   presc       = ctrl_a_reg[3:1];
   wire [2:0]   wg_mode     = mode_reg[2:0];
   wire         auto_lock   = mode_reg[TPC_BIT_AUTO_LOCK_UPDATE];
   wire [2:0]   cmp_en      = mode_reg[TPC_BIT_CMPEN +: 3];
   wire         wr_cmd_clr  = wr_in && addr_in == TPC_OFS_CMD_CLR;
   wire         wr_cmd_set  = wr_in && addr_in == TPC_OFS_CMD_SET;
   wire [1:0]   cmd         = (wr_cmd_clr || wr_cmd_set) ? wdata_in[3:2] : TPC_CMD_NONE;
   wire         dual_slope  = wg_mode[2] && (wg_mode != 3'h4);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler tick select
   logic tick;
   always_comb begin
      case (presc)
         3'h0: tick = 1'b1;
         3'h1: tick = pre_reg[0];
         3'h2: tick = &pre_reg[1:0];
         3'h3: tick = &pre_reg[2:0];
         3'h4: tick = &pre_reg[3:0];
         3'h5: tick = &pre_reg[5:0];
         3'h6: tick = &pre_reg[7:0];
         default: tick = &pre_reg[9:0];
      endcase
   end
   wire run = enable && tick;

   wire [15:0] top_val = (wg_mode == TPC_WG_FREQ) ? cmp_reg[0] : top_reg;
   wire at_top    = (count_reg == top_val) && !dir_reg;
   wire at_bottom = (count_reg == TPC_RST_WORD) && dir_reg;
   wire bot_single = (count_reg == top_val) && !dir_reg;

   // Update points; dual slope at bottom
   logic upd_pt;
   logic ovf_pt;
   always_comb begin
      case (wg_mode)
         TPC_WG_NORMAL, TPC_WG_FREQ: begin
            upd_pt = at_top;
            ovf_pt = at_top;
         end
         TPC_WG_ONE_RAMP: begin
            upd_pt = bot_single;
            ovf_pt = bot_single;
         end
         TPC_WG_DS_TOP: begin
            upd_pt = at_bottom;
            ovf_pt = at_top;
         end
         TPC_WG_DS_BOTH: begin
            upd_pt = at_bottom;
            ovf_pt = at_top || at_bottom;
         end
         TPC_WG_DS_BOTTOM: begin
            upd_pt = at_bottom;
            ovf_pt = at_bottom;
         end
         default: begin
            upd_pt = 1'b0;
            ovf_pt = 1'b0;
         end
      endcase
   end
   wire update_cond = (run && upd_pt) || cmd == TPC_CMD_UPDATE;
   wire transfer    = update_cond && !lock_update_reg;
   wire hard_reset  = cmd == TPC_CMD_RESET && !enable;
   wire restart     = cmd == TPC_CMD_RESTART;

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   wire wr_a    = wr_in && addr_in == TPC_OFS_CTRL_A;
   wire wr_mode = wr_in && addr_in == TPC_OFS_MODE;
   wire wr_lvl  = wr_in && addr_in == TPC_OFS_LEVEL;
   wire wr_spl  = wr_in && addr_in == TPC_OFS_SPLIT;
   wire wr_bvc  = wr_in && addr_in == TPC_OFS_BV_CLR;
   wire wr_bvs  = wr_in && addr_in == TPC_OFS_BV_SET;
   wire wr_lo   = wr_in && !addr_in[0];
   wire wr_hi   = wr_in && addr_in[0];
   wire [7:0] word_a = {addr_in[7:1], 1'b0};
   wire [15:0] wword = {wdata_in, temp_reg};

   wire [3:0] bv_written;
   assign bv_written[0] = wr_hi && word_a == TPC_OFS_TOP_BUF;
   genvar g;
   generate
      for (g = 0; g < TPC_CH; g++) begin : g_bv
         assign bv_written[g+1] = wr_hi && word_a == TPC_OFS_CMP0_BUF + 8'(2*g);
      end
   endgenerate

   wire all_valid = &(bv_reg[3:1] | ~cmp_en);

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ctrl_a_reg <= TPC_RST_BYTE;
         mode_reg   <= TPC_RST_BYTE;
         split_reg  <= 1'b0;
         temp_reg   <= TPC_RST_BYTE;
         pre_reg    <= '0;
      end else if (clk_en_in) begin
         pre_reg <= enable ? pre_reg + 10'h001 : '0;
         if (wr_a)
            ctrl_a_reg <= {wdata_in[7], 3'h0, wdata_in[3:0]};
         if (wr_mode)
            mode_reg <= {1'b0, wdata_in[6:0]};
         if (wr_spl)
            split_reg <= wdata_in[0];
         if (wr_lo)
            temp_reg <= wdata_in;
         if (hard_reset) begin
            ctrl_a_reg <= TPC_RST_BYTE;
            mode_reg   <= TPC_RST_BYTE;
            split_reg  <= 1'b0;
         end
      end
   end

   // Lock, direction and buffer valid
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         lock_update_reg <= 1'b0;
         dir_reg         <= 1'b0;
         bv_reg          <= 4'h0;
      end else if (clk_en_in) begin
         if (wr_cmd_clr) begin
            lock_update_reg <= lock_update_reg & ~wdata_in[1];
            dir_reg         <= dir_reg & ~wdata_in[0];
         end
         if (wr_cmd_set) begin
            lock_update_reg <= lock_update_reg | wdata_in[1];
            dir_reg         <= dir_reg | wdata_in[0];
         end
         // Hardware turns direction in dual slope
         if (run && dual_slope && at_top)
            dir_reg <= 1'b1;
         else if (run && dual_slope && at_bottom)
            dir_reg <= 1'b0;
         if (auto_lock) begin
            if (transfer)
               lock_update_reg <= 1'b1;
            else if (lock_update_reg && all_valid)
               lock_update_reg <= 1'b0;
         end
         // Valid clears on update, write wins
         if (wr_bvc)
            bv_reg <= bv_reg & ~wdata_in[3:0];
         if (transfer)
            bv_reg <= 4'h0;
         if (wr_bvs)
            bv_reg <= bv_reg | wdata_in[3:0];
         bv_reg[0] <= bv_written[0] | (bv_reg[0] & ~transfer & ~(wr_bvc & wdata_in[0]))
                      | (wr_bvs & wdata_in[0]);
         for (int i = 1; i < 4; i++)
            bv_reg[i] <= bv_written[i] | (bv_reg[i] & ~transfer & ~(wr_bvc & wdata_in[i]))
                         | (wr_bvs & wdata_in[i]);
         if (hard_reset) begin
            lock_update_reg <= 1'b0;
            dir_reg         <= 1'b0;
            bv_reg          <= 4'h0;
         end
      end
   end

   // Counter, period and compare registers
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         count_reg   <= TPC_RST_WORD;
         top_reg     <= TPC_RST_TOP;
         top_buf_reg <= TPC_RST_TOP;
         for (int i = 0; i < TPC_CH; i++) begin
            cmp_reg[i]  <= TPC_RST_WORD;
            cbuf_reg[i] <= TPC_RST_WORD;
         end
      end else if (clk_en_in) begin
         // Up when zero, down when one
         if (run) begin
            if (!dir_reg)
               count_reg <= (at_top && !dual_slope) ? TPC_RST_WORD : count_reg + 16'h0001;
            else
               count_reg <= (count_reg == TPC_RST_WORD && !dual_slope) ? top_val
                            : count_reg - 16'h0001;
            if (dual_slope && at_top)
               count_reg <= count_reg - 16'h0001;
            if (dual_slope && at_bottom)
               count_reg <= count_reg + 16'h0001;
         end
         if (wr_hi && word_a == TPC_OFS_COUNT)
            count_reg <= wword;
         if (wr_hi && word_a == TPC_OFS_TOP)
            top_reg <= wword;
         if (bv_written[0])
            top_buf_reg <= wword;
         for (int i = 0; i < TPC_CH; i++) begin
            if (wr_hi && word_a == TPC_OFS_CMP0 + 8'(2*i))
               cmp_reg[i] <= wword;
            if (bv_written[i+1])
               cbuf_reg[i] <= wword;
         end
         if (transfer) begin
            if (bv_reg[0])
               top_reg <= top_buf_reg;
            for (int i = 0; i < TPC_CH; i++)
               if (bv_reg[i+1])
                  cmp_reg[i] <= cbuf_reg[i];
         end
         if (restart)
            count_reg <= TPC_RST_WORD;
         if (hard_reset) begin
            count_reg   <= TPC_RST_WORD;
            top_reg     <= TPC_RST_TOP;
            top_buf_reg <= TPC_RST_TOP;
            for (int i = 0; i < TPC_CH; i++) begin
               cmp_reg[i]  <= TPC_RST_WORD;
               cbuf_reg[i] <= TPC_RST_WORD;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Waveform generator
   logic [TPC_CH-1:0] wave_next;
   always_comb begin
      wave_next = wave_reg;
      for (int i = 0; i < TPC_CH; i++) begin
         if (wg_mode == TPC_WG_FREQ)
            wave_next[i] = (run && at_top) ? ~wave_reg[i] : wave_reg[i];
         else if (wg_mode == TPC_WG_ONE_RAMP)
            wave_next[i] = run ? (count_reg + 16'h0001 < cmp_reg[i] || bot_single)
                               : wave_reg[i];
         else if (dual_slope)
            wave_next[i] = run ? (count_reg < cmp_reg[i]) : wave_reg[i];
      end
   end

   wire [TPC_CH-1:0] wave_d = hard_reset ? 3'h0
                              : (wr_lvl && !enable) ? wdata_in[2:0] : wave_next;
   // Pin override only outside normal mode
   wire [TPC_CH-1:0] ovr_d  = (wg_mode == TPC_WG_NORMAL) ? 3'h0 : cmp_en;
   // Pin level built from the same next values, so it never lags its override
   logic [TPC_CH-1:0] wout_reg;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         wave_reg  <= 3'h0;
         level_reg <= 3'h0;
         ovr_reg   <= 3'h0;
         wout_reg  <= 3'h0;
         ovf_reg   <= 1'b0;
      end else if (clk_en_in) begin
         wave_reg <= wave_d;
         if (wr_lvl)
            level_reg <= wdata_in[2:0];
         ovr_reg  <= ovr_d;
         wout_reg <= wave_d & ovr_d;
         ovf_reg  <= run && ovf_pt;
         if (hard_reset)
            level_reg <= 3'h0;
      end
   end
   assign waveform_output_n_out = wout_reg;
   assign pin_override_out      = ovr_reg;
   assign overflow_out          = ovf_reg;
   assign split_mode_select_out = split_reg;

   ////////////////////////////////////////////////////////////////////////
   // Read path; command field reads zero
   wire [7:0] e_read = {6'h00, lock_update_reg, dir_reg};
   logic [7:0] rmux;
   always_comb begin
      case (addr_in)
         TPC_OFS_CTRL_A:  rmux = ctrl_a_reg;
         TPC_OFS_MODE:    rmux = mode_reg;
         TPC_OFS_LEVEL:   rmux = enable ? {5'h00, level_reg} : {5'h00, wave_reg};
         TPC_OFS_SPLIT:   rmux = {7'h00, split_reg};
         TPC_OFS_CMD_CLR, TPC_OFS_CMD_SET: rmux = e_read;
         TPC_OFS_BV_CLR, TPC_OFS_BV_SET:   rmux = {4'h0, bv_reg};
         default:         rmux = 8'h00;
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (!reset_n_in)
         rdata_reg <= 8'h00;
      else if (clk_en_in)
         rdata_reg <= rd_in ? rmux : 8'h00;
   end
   assign rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Hard reset refused while enabled
   property p_hard_reset_ignored;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && enable && wr_cmd_set && wdata_in[3:2] == TPC_CMD_RESET)
         |=> ctrl_a_reg[0];
   endproperty
   a_hard_reset_ignored: assert property (p_hard_reset_ignored)
      else $error("hard reset acted while enabled");

   property p_lock_stable;
      @(posedge clk_in) disable iff (!reset_n_in)
      (!auto_lock && !wr_cmd_clr && !wr_cmd_set && !hard_reset) |=> $stable(lock_update_reg);
   endproperty
   a_lock_stable: assert property (p_lock_stable)
      else $error("lock changed without software");

   property p_no_copy_locked;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && lock_update_reg && !hard_reset
       && !(wr_in && addr_in == TPC_OFS_CMP0 + 8'h01)) |=> $stable(cmp_reg[0]);
   endproperty
   a_no_copy_locked: assert property (p_no_copy_locked)
      else $error("compare changed while locked");

   property p_normal_quiet;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && wg_mode == TPC_WG_NORMAL) |=> pin_override_out == 3'h0;
   endproperty
   a_normal_quiet: assert property (p_normal_quiet)
      else $error("pin driven in normal mode");

   property p_valid_on_write;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && bv_written[1]) |=> bv_reg[1];
   endproperty
   a_valid_on_write: assert property (p_valid_on_write)
      else $error("buffer write left valid flag clear");

   property p_count_down;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && run && dir_reg && !dual_slope && count_reg != TPC_RST_WORD && !wr_in)
         |=> count_reg == $past(count_reg) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("down count did not decrement");

   property p_stopped_quiet;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && !enable) |=> !overflow_out;
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet)
      else $error("overflow while disabled");
endmodule : tpc_timer
`default_nettype wire

// ===== verif/tpc_timer_test.sv
// Self-checking bench for the timer control block: register port, outputs.
// Assumes a 250 MHz clock and the register map of tpc_pkg; no partner model.
`timescale 1ns/1ns
`default_nettype none
module tpc_timer_test
   import tpc_pkg::*;
;
   logic              clk_in      = 1'b0;
   logic              reset_n_in  = 1'b0;
   logic              clk_en_in   = 1'b1;
   logic [7:0]        addr_in     = 8'h00;
   logic [7:0]        wdata_in    = 8'h00;
   logic              wr_in       = 1'b0;
   logic              rd_in       = 1'b0;
   logic [7:0]        rdata_out;
   logic [TPC_CH-1:0] waveform_output_n_out;
   logic [TPC_CH-1:0] pin_override_out;
   logic              overflow_out;
   logic              split_mode_select_out;
   int                mismatches  = 0;
   int                checks_done = 0;
   int                seed        = 47;
   int                g;
   int                i;
   logic [7:0]        rv;
   logic [7:0]        v;

   always #2 clk_in = ~clk_in;

   tpc_timer dut (
      .clk_in                (clk_in),
      .reset_n_in            (reset_n_in),
      .clk_en_in             (clk_en_in),
      .addr_in               (addr_in),
      .wdata_in              (wdata_in),
      .wr_in                 (wr_in),
      .rd_in                 (rd_in),
      .rdata_out             (rdata_out),
      .waveform_output_n_out (waveform_output_n_out),
      .pin_override_out      (pin_override_out),
      .overflow_out          (overflow_out),
      .split_mode_select_out (split_mode_select_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (mismatches == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One-cycle write strobe; the release lands a cycle before the next request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe is taken
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1;
      chk({8'h00, rdata_out & mask}, {8'h00, exp}, "read");
   endtask

   function automatic int div_of(input logic [2:0] code);
      case (code)
         3'h5: return 64;
         3'h6: return 256;
         3'h7: return 1024;
         default: return 1 << code;
      endcase
   endfunction

   // Top is 3 and compare 0 is 5 during the overflow runs
   function automatic int exp_gap(input logic [2:0] mode, input logic [2:0] code);
      case (mode)
         TPC_WG_FREQ: return 6 * div_of(code);
         TPC_WG_DS_TOP, TPC_WG_DS_BOTTOM: return 6 * div_of(code);
         TPC_WG_DS_BOTH: return 3 * div_of(code);
         default: return 4 * div_of(code);
      endcase
   endfunction

   // Cycles between the second and third overflow pulse, bounded
   task automatic gap(output int n);
      int k;
      int e;
      e = 0;
      n = 0;
      for (k = 0; k < 20000 && e < 3; k++) begin
         @(posedge clk_in);
         #1;
         if (e > 1) n++;
         if (overflow_out === 1'b1) e++;
      end
   endtask

   // Restart from bottom counting up, so a stale count cannot skew the gap
   task automatic run(input logic [2:0] mode, input logic [2:0] code);
      wr(TPC_OFS_CTRL_A, 8'h00);
      wr(TPC_OFS_MODE, {5'h00, mode});
      wr(TPC_OFS_CMD_CLR, 8'h01);
      wr(TPC_OFS_CMD_SET, 8'h08);
      wr(TPC_OFS_CTRL_A, {4'h0, code, 1'b1});
      gap(g);
      chk(16'(g), 16'(exp_gap(mode, code)), "overflow gap");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      mismatches++;
      close_out();
   end

   initial begin
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      for (i = 0; i < 8; i++) rchk(i[7:0], 8'h00, 8'hff);
      rchk(8'h10, 8'h00, 8'hff);
      rchk(TPC_OFS_TOP, 8'h00, 8'hff);
      chk(16'(pin_override_out), 16'h0000, "pin after reset");
      // First pass is normal mode with all channels enabled
      rv = 8'h70;
      repeat (8) begin
         wr(TPC_OFS_MODE, rv & 8'h77);
         rchk(TPC_OFS_MODE, rv & 8'h77, 8'h7f);
         v = (rv[2:0] == TPC_WG_NORMAL) ? 8'h00 : {5'h00, rv[6:4]};
         chk(16'(pin_override_out), 16'(v), "override");
         rv = 8'($random(seed));
      end
      wr(TPC_OFS_CTRL_A, rv & 8'h8e);
      rchk(TPC_OFS_CTRL_A, rv & 8'h8e, 8'h8f);
      wr(TPC_OFS_SPLIT, 8'h01);
      #1;
      chk(16'(split_mode_select_out), 16'h0001, "split");
      wr(TPC_OFS_SPLIT, 8'h00);
      wr(TPC_OFS_MODE, 8'h00);
      wr(TPC_OFS_CMD_SET, 8'h03);
      rchk(TPC_OFS_CMD_CLR, 8'h03, 8'h0f);
      wr(TPC_OFS_CMD_CLR, 8'h01);
      wr(TPC_OFS_CMD_SET, 8'h04);
      rchk(TPC_OFS_CMD_SET, 8'h02, 8'h0f);
      wr(TPC_OFS_CMP0_BUF, 8'h11);
      wr(TPC_OFS_CMP0_BUF + 8'h01, 8'h00);
      rchk(TPC_OFS_BV_SET, 8'h02, 8'h0f);
      wr(TPC_OFS_CMD_SET, 8'h04);
      rchk(TPC_OFS_BV_SET, 8'h02, 8'h0f);
      rchk(TPC_OFS_CMD_SET, 8'h02, 8'h0f);
      wr(TPC_OFS_CMD_CLR, 8'h02);
      wr(TPC_OFS_CMD_CLR, 8'h04);
      rchk(TPC_OFS_BV_SET, 8'h00, 8'h0f);
      wr(TPC_OFS_MODE, 8'h18);
      wr(TPC_OFS_CMD_SET, 8'h02);
      rchk(TPC_OFS_CMD_SET, 8'h02, 8'h0f);
      wr(TPC_OFS_CMP0_BUF, 8'h22);
      wr(TPC_OFS_CMP0_BUF + 8'h01, 8'h00);
      rchk(TPC_OFS_CMD_SET, 8'h00, 8'h0f);
      wr(TPC_OFS_CMD_SET, 8'h04);
      rchk(TPC_OFS_CMD_SET, 8'h02, 8'h0f);
      rchk(TPC_OFS_BV_SET, 8'h00, 8'h0f);
      wr(TPC_OFS_MODE, 8'h71);
      wr(TPC_OFS_CTRL_A, 8'h01);
      wr(TPC_OFS_CMD_SET, 8'h0c);
      rchk(TPC_OFS_MODE, 8'h71, 8'h7f);
      wr(TPC_OFS_CTRL_A, 8'h00);
      wr(TPC_OFS_CMD_SET, 8'h0c);
      rchk(TPC_OFS_MODE, 8'h00, 8'h7f);
      // Stalled clock enable: the write must not land
      @(posedge clk_in);
      clk_en_in <= 1'b0;
      wr(TPC_OFS_MODE, 8'h71);
      clk_en_in <= 1'b1;
      rchk(TPC_OFS_MODE, 8'h00, 8'h7f);
      wr(TPC_OFS_MODE, 8'h71);
      for (i = 0; i < 8; i++) begin
         wr(TPC_OFS_LEVEL, i[7:0]);
         @(posedge clk_in);
         #1;
         chk(16'(waveform_output_n_out), 16'(i[2:0]), "level");
         rchk(TPC_OFS_LEVEL, i[7:0], 8'h07);
      end
      wr(TPC_OFS_TOP, 8'h03);
      wr(TPC_OFS_TOP + 8'h01, 8'h00);
      wr(TPC_OFS_CMP0, 8'h05);
      wr(TPC_OFS_CMP0 + 8'h01, 8'h00);
      for (i = 0; i < 8; i++) run(TPC_WG_NORMAL, i[2:0]);
      run(TPC_WG_FREQ, 3'h0);
      run(TPC_WG_ONE_RAMP, 3'h1);
      run(TPC_WG_DS_TOP, 3'h0);
      run(TPC_WG_DS_BOTH, 3'h0);
      run(TPC_WG_DS_BOTTOM, 3'h0);
      // Down counting in normal mode: restart with direction set, run a while
      wr(TPC_OFS_CTRL_A, 8'h00);
      wr(TPC_OFS_MODE, 8'h00);
      wr(TPC_OFS_CMD_SET, 8'h09);
      wr(TPC_OFS_CTRL_A, 8'h01);
      repeat (50) @(posedge clk_in);
      wr(TPC_OFS_CTRL_A, 8'h00);
      g = 0;
      for (i = 0; i < 2000; i++) begin
         @(posedge clk_in);
         #1;
         if (i > 2 && overflow_out !== 1'b0) g++;
      end
      chk(16'(g), 16'h0000, "stopped counter");
      close_out();
   end
endmodule // tpc_timer_test
`default_nettype wire
